// File: wbs_pkg.sv
// constants and types shared by the wake and board signal logic
// ****************************************************************
// Overview of operation
// - pm event pin from flag/enable or override
// - pm event pin needs no clock
// - first lamp defaults to link active
// - second lamp defaults to receive activity
// - fourth lamp defaults to transmit activity
// - lamp polarity programmable, low means open drain
// - every lamp selects its own status source
// - last reset edge samples second lamp pin
// - power low plus enable enters wake mode
// - power low: reset only floats bus pins
// - power high: reset clears logic, loads eeprom
// - remote wake on frame or link change
// - loaded polarity, drive style, gate control wake
// - remote wake floats until configuration loaded
// - wake mode indicator follows wake mode
// - time base from oscillator or external pin
// - time base paces eeprom, transceiver reset, management
// - transceiver reset follows bus reset, power gated
// - bit zero sets transceiver reset polarity
// ****************************************************************
package wbs_pkg;

   // ****************************************************************
   // clock and time base
   // ****************************************************************
   localparam int         CLK_HZ       = 20_000_000;
   localparam int         OSC_MAX_HZ   = 20_000_000;
   // a maximum frequency rounds the divide ratio up
   localparam int         OSC_DIV      = (CLK_HZ + OSC_MAX_HZ - 1)
                                         / OSC_MAX_HZ;
   localparam logic [3:0] OSC_DIV_LAST = 4'(OSC_DIV - 1);

   // ****************************************************************
   // synchroniser lanes
   // ****************************************************************
   localparam int SYN_W      = 5;
   localparam int SYN_RST    = 0;
   localparam int SYN_PG     = 1;
   localparam int SYN_LAMP1  = 2;
   localparam int SYN_TB_SEL = 3;
   localparam int SYN_EXT_TB = 4;
   localparam logic [SYN_W-1:0] SYN_RST_VAL = 5'h00;

   // ****************************************************************
   // lamp status sources and reset configuration
   // ****************************************************************
   localparam logic [1:0] ST_LINK = 2'h0;
   localparam logic [1:0] ST_RX   = 2'h1;
   localparam logic [1:0] ST_TX   = 2'h2;
   localparam logic [1:0] ST_COL  = 2'h3;
   // two bits per lamp, lamp 0 in the low bits
   localparam logic [7:0] LAMP_SEL_RST  = {ST_TX, ST_COL, ST_RX, ST_LINK};
   localparam logic       LAMP_HIGH_RST = 1'b0;

   // ****************************************************************
   // wake configuration word
   // ****************************************************************
   localparam int         WCFG_TRANSCEIVER_RESET_POLARITY = 0;
   localparam int         WCFG_POL     = 1;
   localparam int         WCFG_GATE    = 2;
   localparam int         WCFG_DRV     = 3;
   localparam logic [3:0] WCFG_RST_VAL = 4'h0;
   localparam logic       XRST_OUT_RST = 1'b1;

   typedef enum logic [1:0] {
      WBS_RUN,
      WBS_HOLD,
      WBS_LOAD
   } wbs_rst_state_t;

endpackage

// File: wbs_sync.sv
// two flip-flop synchroniser for the asynchronous board inputs
`timescale 1ns/1ps
module wbs_sync
   import wbs_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             ce,
   input  wire logic [SYN_W-1:0] d,
   output logic      [SYN_W-1:0] q
);

   logic [SYN_W-1:0] meta_ff;
   logic [SYN_W-1:0] sync_ff;

   // ****************************************************************
   // capture stages
   // ****************************************************************
   // first stage feeds only the second stage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_ff <= SYN_RST_VAL;
         sync_ff <= SYN_RST_VAL;
      end else if (ce) begin
         meta_ff <= d;
         sync_ff <= meta_ff;
      end
   end

   assign q = sync_ff;

endmodule

// File: wbs_lamp.sv
// one status lamp driver with programmable source and polarity
`timescale 1ns/1ps
module wbs_lamp
   import wbs_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       ce,
   input  wire logic [3:0] status,
   input  wire logic [1:0] sel,
   input  wire logic       act_high,
   input  wire logic       quiet,
   output logic            pin_out,
   output logic            pin_oe
);

   logic lit;

   // source select, forced dark while quiet
   assign lit = status[sel] & ~quiet;

   // ****************************************************************
   // pin drive
   // ****************************************************************
   // active low only sinks so a strap resistor still wins when dark
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_out <= 1'b0;
         pin_oe  <= 1'b0;
      end else if (ce) begin
         if (act_high) begin
            pin_out <= lit;
            pin_oe  <= ~quiet;
         end else begin
            pin_out <= 1'b0;
            pin_oe  <= lit;
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_lamp_open_drain: assert property (
      (ce && !act_high) |=> (!pin_out && pin_oe == $past(lit)))
      else $error("active low lamp drove high or wrong enable");

   a_lamp_totem_pole: assert property (
      (ce && act_high && !quiet) |=> (pin_oe && pin_out == $past(lit)))
      else $error("active high lamp not driving its level");

endmodule

// File: wbs_wake_board.sv
// top level of the wake, reset, time base and lamp board logic
`timescale 1ns/1ps
module wbs_wake_board
   import wbs_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       ce,
   input  wire logic       pci_rst_n,
   input  wire logic       power_good_in,
   input  wire logic       pm_event_flag,
   input  wire logic       pm_event_enable,
   input  wire logic       pm_enable_override,
   input  wire logic       wake_frame_match,
   input  wire logic       link_change_seen,
   input  wire logic       wake_frame_pin_enable,
   input  wire logic       wake_frame_mode_enable,
   input  wire logic       link_change_mode_enable,
   input  wire logic       net_link_up,
   input  wire logic       net_rx_active,
   input  wire logic       net_tx_active,
   input  wire logic       net_collision,
   input  wire logic       lamp_cfg_we,
   input  wire logic [1:0] lamp_cfg_idx,
   input  wire logic [1:0] lamp_cfg_sel,
   input  wire logic       lamp_cfg_high,
   input  wire logic       rx_activity_lamp_in,
   input  wire logic       wake_cfg_load,
   input  wire logic [3:0] wake_cfg_word,
   input  wire logic       eeprom_load_done,
   input  wire logic       time_base_select,
   input  wire logic       ext_time_base_clock,
   output logic            pme_out,
   output logic            pme_oe,
   output logic            link_lamp_out,
   output logic            link_lamp_oe,
   output logic            rx_activity_lamp_out,
   output logic            rx_activity_lamp_oe,
   output logic            aux_status_lamp_out,
   output logic            aux_status_lamp_oe,
   output logic            tx_activity_lamp_out,
   output logic            tx_activity_lamp_oe,
   output logic            eeprom_present,
   output logic            pci_float,
   output logic            ctl_reset,
   output logic            eeprom_load_req,
   output logic            wake_mode_indicator,
   output logic            remote_wake_out,
   output logic            remote_wake_oe,
   output logic            time_base_tick,
   output logic            transceiver_reset_out
);

   // ****************************************************************
   // input synchronisers
   // ****************************************************************
   logic [SYN_W-1:0] syn_in;
   logic [SYN_W-1:0] syn_q;
   logic             pci_rst_s;
   logic             pg_s;
   logic             lamp1_s;
   logic             tb_sel_s;
   logic             ext_tb_s;
   logic             hard_rst;

   assign syn_in[SYN_RST]    = pci_rst_n;
   assign syn_in[SYN_PG]     = power_good_in;
   assign syn_in[SYN_LAMP1]  = rx_activity_lamp_in;
   assign syn_in[SYN_TB_SEL] = time_base_select;
   assign syn_in[SYN_EXT_TB] = ext_time_base_clock;

   wbs_sync u_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .ce    (ce),
      .d     (syn_in),
      .q     (syn_q)
   );

   assign pci_rst_s = syn_q[SYN_RST];
   assign pg_s      = syn_q[SYN_PG];
   assign lamp1_s   = syn_q[SYN_LAMP1];
   assign tb_sel_s  = syn_q[SYN_TB_SEL];
   assign ext_tb_s  = syn_q[SYN_EXT_TB];

   // bus reset only counts while main power is good
   assign hard_rst = ~pci_rst_s & pg_s;

   // ****************************************************************
   // power management event pin
   // ****************************************************************
   // pure gates so the pin works with the bus clock stopped
   assign pme_oe  = (pm_event_flag & pm_event_enable)
                  | (pm_enable_override
                     & (wake_frame_match | link_change_seen));
   // open drain: only ever sinks
   assign pme_out = 1'b0;

   // ****************************************************************
   // reset sequencing
   // ****************************************************************
   wbs_rst_state_t state_ff;
   wbs_rst_state_t nxt_state;

   // hold in reset, then ask for the configuration load
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         WBS_RUN: begin
            if (hard_rst) begin
               nxt_state = WBS_HOLD;
            end
         end
         WBS_HOLD: begin
            if (pci_rst_s) begin
               nxt_state = WBS_LOAD;
            end
         end
         WBS_LOAD: begin
            if (hard_rst) begin
               nxt_state = WBS_HOLD;
            end else if (eeprom_load_done) begin
               nxt_state = WBS_RUN;
            end
         end
         default: begin
            nxt_state = WBS_RUN;
         end
      endcase
   end

   // power-on starts in hold so the first release loads the eeprom
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff        <= WBS_HOLD;
         ctl_reset       <= 1'b1;
         eeprom_load_req <= 1'b0;
      end else if (ce) begin
         state_ff        <= nxt_state;
         ctl_reset       <= (nxt_state == WBS_HOLD);
         eeprom_load_req <= (nxt_state == WBS_LOAD);
      end
   end

   // bus pins float on any reset, power good or not
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pci_float <= 1'b1;
      end else if (ce) begin
         pci_float <= ~pci_rst_s;
      end
   end

   // strap capture: the value of the last reset edge stands
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         eeprom_present <= 1'b0;
      end else if (ce && hard_rst) begin
         eeprom_present <= lamp1_s;
      end
   end

   // ****************************************************************
   // status lamps
   // ****************************************************************
   logic [3:0] net_st;
   logic [1:0] lamp_sel_ff  [4];
   logic       lamp_high_ff [4];
   logic [3:0] lamp_out_w;
   logic [3:0] lamp_oe_w;

   assign net_st[ST_LINK] = net_link_up;
   assign net_st[ST_RX]   = net_rx_active;
   assign net_st[ST_TX]   = net_tx_active;
   assign net_st[ST_COL]  = net_collision;

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_lamp
         // per-lamp source and polarity, defaults restored by reset
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               lamp_sel_ff[gi]  <= LAMP_SEL_RST[2*gi +: 2];
               lamp_high_ff[gi] <= LAMP_HIGH_RST;
            end else if (ce) begin
               if (hard_rst) begin
                  lamp_sel_ff[gi]  <= LAMP_SEL_RST[2*gi +: 2];
                  lamp_high_ff[gi] <= LAMP_HIGH_RST;
               end else if (lamp_cfg_we && lamp_cfg_idx == 2'(gi)) begin
                  lamp_sel_ff[gi]  <= lamp_cfg_sel;
                  lamp_high_ff[gi] <= lamp_cfg_high;
               end
            end
         end

         // dark during reset so the strap on lamp 1 is readable
         wbs_lamp u_lamp (
            .clk      (clk),
            .rst_n    (rst_n),
            .ce       (ce),
            .status   (net_st),
            .sel      (lamp_sel_ff[gi]),
            .act_high (lamp_high_ff[gi]),
            .quiet    (hard_rst),
            .pin_out  (lamp_out_w[gi]),
            .pin_oe   (lamp_oe_w[gi])
         );
      end
   endgenerate

   assign link_lamp_out        = lamp_out_w[0];
   assign link_lamp_oe         = lamp_oe_w[0];
   assign rx_activity_lamp_out = lamp_out_w[1];
   assign rx_activity_lamp_oe  = lamp_oe_w[1];
   assign aux_status_lamp_out  = lamp_out_w[2];
   assign aux_status_lamp_oe   = lamp_oe_w[2];
   assign tx_activity_lamp_out = lamp_out_w[3];
   assign tx_activity_lamp_oe  = lamp_oe_w[3];

   // ****************************************************************
   // wake mode and remote wake pin
   // ****************************************************************
   logic wake_req_ff;
   logic rw_pol_ff;
   logic rw_gate_ff;
   logic rw_drv_ff;
   logic xrst_pol_ff;
   logic wcfg_valid_ff;
   logic rw_level;

   // wake mode only while main power is away
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wake_mode_indicator <= 1'b0;
      end else if (ce) begin
         wake_mode_indicator <= ~pg_s & (wake_frame_pin_enable
                                | wake_frame_mode_enable);
      end
   end

   // detected wake condition, level while the cause stands
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wake_req_ff <= 1'b0;
      end else if (ce) begin
         wake_req_ff <= (wake_mode_indicator & wake_frame_match)
                      | (link_change_mode_enable
                         & link_change_seen);
      end
   end

   // configuration survives bus resets; only power-on clears it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         xrst_pol_ff   <= WCFG_RST_VAL[WCFG_TRANSCEIVER_RESET_POLARITY];
         rw_pol_ff     <= WCFG_RST_VAL[WCFG_POL];
         rw_gate_ff    <= WCFG_RST_VAL[WCFG_GATE];
         rw_drv_ff     <= WCFG_RST_VAL[WCFG_DRV];
         wcfg_valid_ff <= 1'b0;
      end else if (ce && wake_cfg_load) begin
         xrst_pol_ff   <= wake_cfg_word[WCFG_TRANSCEIVER_RESET_POLARITY];
         rw_pol_ff     <= wake_cfg_word[WCFG_POL];
         rw_gate_ff    <= wake_cfg_word[WCFG_GATE];
         rw_drv_ff     <= wake_cfg_word[WCFG_DRV];
         wcfg_valid_ff <= 1'b1;
      end
   end

   // polarity one means the asserted level is high
   assign rw_level = rw_pol_ff ? wake_req_ff : ~wake_req_ff;

   // float until configured, or when gated with power low
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         remote_wake_out <= 1'b0;
         remote_wake_oe  <= 1'b0;
      end else if (ce) begin
         if (!wcfg_valid_ff || (rw_gate_ff && !pg_s)) begin
            remote_wake_out <= 1'b0;
            remote_wake_oe  <= 1'b0;
         end else if (rw_drv_ff) begin
            remote_wake_out <= rw_level;
            remote_wake_oe  <= 1'b1;
         end else begin
            remote_wake_out <= 1'b0;
            remote_wake_oe  <= ~rw_level;
         end
      end
   end

   // ****************************************************************
   // time base and transceiver reset
   // ****************************************************************
   logic [3:0] osc_cnt_ff;
   logic       osc_tick;
   logic       ext_prev_ff;
   logic       tb_tick;

   assign osc_tick = (osc_cnt_ff == OSC_DIV_LAST);

   // internal oscillator stands in as the system clock divided by OSC_DIV, which is one, so it ticks every enabled cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         osc_cnt_ff  <= 4'h0;
         ext_prev_ff <= 1'b0;
      end else if (ce) begin
         osc_cnt_ff  <= osc_tick ? 4'h0 : osc_cnt_ff + 4'h1;
         ext_prev_ff <= ext_tb_s;
      end
   end

   // external clock must stay below half the system clock
   assign tb_tick = tb_sel_s ? (ext_tb_s & ~ext_prev_ff)
                             : osc_tick;

   // tick exported to eeprom and management timing
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         time_base_tick <= 1'b0;
      end else if (ce) begin
         time_base_tick <= tb_tick;
      end
   end

   // transceiver reset moves only on time base ticks
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         transceiver_reset_out <= XRST_OUT_RST;
      end else if (ce && tb_tick) begin
         transceiver_reset_out <= hard_rst ? xrst_pol_ff
                                           : ~xrst_pol_ff;
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   logic lamp_touched_ff;

   // marks that software has reprogrammed any lamp
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lamp_touched_ff <= 1'b0;
      end else if (ce && lamp_cfg_we) begin
         lamp_touched_ff <= 1'b1;
      end
   end

   sequence seq_reset_entry;
      ce && state_ff == WBS_RUN && hard_rst;
   endsequence

   sequence seq_reset_release;
      ce && state_ff == WBS_HOLD && pci_rst_s;
   endsequence

   a_pme_event: assert property (
      (pm_event_flag && pm_event_enable) |-> pme_oe)
      else $error("pm event pin idle with flag and enable set");

   a_pme_cause: assert property (
      pme_oe |-> ((pm_event_flag && pm_event_enable)
                  || (pm_enable_override
                      && (wake_frame_match || link_change_seen))))
      else $error("pm event pin asserted without a cause");

   a_lamp0_default: assert property (
      !lamp_touched_ff |-> lamp_sel_ff[0] == ST_LINK)
      else $error("lamp 0 default source is not link");

   a_lamp1_default: assert property (
      !lamp_touched_ff |-> lamp_sel_ff[1] == ST_RX)
      else $error("lamp 1 default source is not receive");

   a_lamp3_default: assert property (
      !lamp_touched_ff |-> lamp_sel_ff[3] == ST_TX)
      else $error("lamp 3 default source is not transmit");

   a_strap_sample: assert property (
      (ce && hard_rst) |=> eeprom_present == $past(lamp1_s))
      else $error("eeprom presence not taken from lamp 1 pin");

   a_wake_mode_entry: assert property (
      (ce && !pg_s && (wake_frame_pin_enable || wake_frame_mode_enable))
      |=> wake_mode_indicator)
      else $error("wake mode not entered with power low");

   a_reset_ignored: assert property (
      (ce && state_ff == WBS_RUN && !pg_s) |=> state_ff == WBS_RUN)
      else $error("internal logic reset while power low");

   a_reset_entry: assert property (
      seq_reset_entry |=> ctl_reset)
      else $error("bus reset did not hold logic");

   a_reset_and_load: assert property (
      seq_reset_release |=> (eeprom_load_req && !ctl_reset))
      else $error("reset did not lead to eeprom load");

   a_wake_request: assert property (
      (ce && wake_mode_indicator && wake_frame_match)
      |=> wake_req_ff)
      else $error("wake frame in wake mode did not raise wake");

   a_wake_gate: assert property (
      (ce && rw_gate_ff && !pg_s) |=> !remote_wake_oe)
      else $error("gated remote wake driven with power low");

   a_wake_unloaded: assert property (
      !wcfg_valid_ff |-> !remote_wake_oe)
      else $error("remote wake driven before configuration");

   a_tb_source: assert property (
      (ce && tb_sel_s && !(ext_tb_s && !ext_prev_ff))
      |=> !time_base_tick)
      else $error("time base ticked without external edge");

   a_xrst_power_low: assert property (
      (ce && tb_tick && !pg_s)
      |=> transceiver_reset_out == !$past(xrst_pol_ff))
      else $error("transceiver reset asserted with power low");

endmodule

// File: wbs_board_model.sv
// board side model: strap resistor on the second lamp pin
`timescale 1ns/1ps
module wbs_board_model (
   input  wire logic strap_up,
   input  wire logic lamp_out,
   input  wire logic lamp_oe,
   output logic      lamp_pin
);
   // a released pin settles at the resistor level, never floats
   assign lamp_pin = lamp_oe ? lamp_out : strap_up;
endmodule

// File: wake_and_board_signal_logic_test.sv
// self-checking bench for the wake and board signal logic
`timescale 1ns/1ps
module wake_and_board_signal_logic_test;
   import wbs_pkg::*;
   logic clk = 0, rst_n = 0, ce = 1, pci_rst_n = 1, power_good_in = 1;
   logic pm_event_flag = 0, pm_event_enable = 0, pm_enable_override = 0;
   logic wake_frame_match = 0, link_change_seen = 0, lamp_cfg_high = 0;
   logic wake_frame_pin_enable = 0, wake_frame_mode_enable = 0;
   logic link_change_mode_enable = 0, net_link_up = 1, net_rx_active = 0;
   logic net_tx_active = 1, net_collision = 0, lamp_cfg_we = 0;
   logic wake_cfg_load = 0, eeprom_load_done = 1, strap_up = 1;
   logic time_base_select = 0, ext_time_base_clock = 0, lamp_pin;
   logic [1:0] lamp_cfg_idx = 0, lamp_cfg_sel = 0;
   logic [3:0] wake_cfg_word = 0;
   logic pme_oe, link_lamp_out, link_lamp_oe, rx_activity_lamp_out;
   logic rx_activity_lamp_oe, aux_status_lamp_out, aux_status_lamp_oe;
   logic tx_activity_lamp_out, tx_activity_lamp_oe, eeprom_present;
   logic pci_float, ctl_reset, eeprom_load_req, wake_mode_indicator;
   logic remote_wake_out, remote_wake_oe, transceiver_reset_out;
   logic time_base_tick;
   int   err_count = 0, n_checks = 0, cycles = 0;
   wbs_wake_board dut (.clk, .rst_n, .ce, .pci_rst_n, .power_good_in,
      .pm_event_flag, .pm_event_enable, .pm_enable_override,
      .wake_frame_match, .link_change_seen, .wake_frame_pin_enable,
      .wake_frame_mode_enable, .link_change_mode_enable, .net_link_up,
      .net_rx_active, .net_tx_active, .net_collision, .lamp_cfg_we,
      .lamp_cfg_idx, .lamp_cfg_sel, .lamp_cfg_high,
      .rx_activity_lamp_in(lamp_pin), .wake_cfg_load, .wake_cfg_word,
      .eeprom_load_done, .time_base_select, .ext_time_base_clock,
      .pme_out(), .pme_oe, .link_lamp_out, .link_lamp_oe,
      .rx_activity_lamp_out, .rx_activity_lamp_oe, .aux_status_lamp_out,
      .aux_status_lamp_oe, .tx_activity_lamp_out, .tx_activity_lamp_oe,
      .eeprom_present, .pci_float, .ctl_reset, .eeprom_load_req,
      .wake_mode_indicator, .remote_wake_out, .remote_wake_oe,
      .time_base_tick, .transceiver_reset_out);
   wbs_board_model board (.strap_up, .lamp_out(rx_activity_lamp_out),
      .lamp_oe(rx_activity_lamp_oe), .lamp_pin);
   // ****************************************************************
   // clock, timeout and shared tasks
   // ****************************************************************
   always #25 clk = ~clk;
   // a hang far beyond the short test run counts as a mismatch
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         err_count++;
         wrap_up();
      end
   end
   task automatic chk(string nm, logic got, logic exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %s expected %b seen %b", nm, exp, got);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic load_wake(logic [3:0] w);
      wake_cfg_word = w;
      wake_cfg_load = 1'h1;
      cyc(1);
      wake_cfg_load = 1'h0;
   endtask
   // lamp defaults, source selection, unloaded remote wake
   task automatic t_lamp;
      {link_change_mode_enable, link_change_seen} = 2'h3;
      cyc(3);
      chk("rwu_oe", remote_wake_oe, 1'h0);
      {link_change_mode_enable, link_change_seen} = 2'h0;
      chk("lamp0_oe", link_lamp_oe, 1'h1);
      chk("lamp0_out", link_lamp_out, 1'h0);
      chk("lamp1_oe", rx_activity_lamp_oe, 1'h0);
      chk("lamp3_oe", tx_activity_lamp_oe, 1'h1);
      {net_rx_active, net_tx_active} = 2'h2;
      cyc(3);
      chk("lamp1_oe", rx_activity_lamp_oe, 1'h1);
      chk("lamp3_oe", tx_activity_lamp_oe, 1'h0);
      {lamp_cfg_idx, lamp_cfg_sel, lamp_cfg_high} = {2'h2, ST_RX, 1'h1};
      lamp_cfg_we = 1'h1;
      cyc(1);
      lamp_cfg_we = 1'h0;
      cyc(3);
      chk("lamp2_out", aux_status_lamp_out, 1'h1);
      net_rx_active = 1'h0;
      cyc(3);
      chk("lamp2_out", aux_status_lamp_out, 1'h0);
      chk("lamp2_oe", aux_status_lamp_oe, 1'h1);
   endtask
   // event pin truth table with every flop frozen
   task automatic t_pme;
      logic [4:0] v;
      ce = 1'h0;
      for (int i = 0; i < 32; i++) begin
         v = 5'(i);
         {pm_event_flag, pm_event_enable, pm_enable_override,
          wake_frame_match, link_change_seen} = v;
         #0.5;
         chk("pme_oe", pme_oe, v[4] & v[3] | v[2] & (v[1] | v[0]));
      end
      cyc(1);
      {pm_event_flag, pm_event_enable, pm_enable_override} = 3'h0;
      {wake_frame_match, link_change_seen} = 2'h0;
      ce = 1'h1;
   endtask
   // strap sampled at the end of a powered bus reset
   task automatic t_strap;
      for (int s = 0; s < 2; s++) begin
         strap_up = 1'(s);
         eeprom_load_done = 1'h0;
         pci_rst_n = 1'h0;
         cyc(6);
         chk("ctl_reset", ctl_reset, 1'h1);
         chk("xcvr_rst", transceiver_reset_out, 1'h0);
         pci_rst_n = 1'h1;
         cyc(1);
         strap_up = ~strap_up;
         cyc(5);
         chk("eeprom_present", eeprom_present, 1'(s));
         chk("load_req", eeprom_load_req, 1'h1);
         eeprom_load_done = 1'h1;
         cyc(2);
         chk("load_req", eeprom_load_req, 1'h0);
      end
   endtask
   // wake mode, remote wake and transceiver reset against power good
   task automatic t_wake;
      load_wake(4'hb);
      {power_good_in, wake_frame_mode_enable, wake_frame_match} = 3'h3;
      cyc(6);
      chk("wake_mode", wake_mode_indicator, 1'h1);
      chk("rwu_out", remote_wake_out, 1'h1);
      chk("rwu_oe", remote_wake_oe, 1'h1);
      pci_rst_n = 1'h0;
      cyc(6);
      chk("pci_float", pci_float, 1'h1);
      chk("ctl_reset", ctl_reset, 1'h0);
      chk("wake_mode", wake_mode_indicator, 1'h1);
      chk("xcvr_rst", transceiver_reset_out, 1'h0);
      pci_rst_n = 1'h1;
      load_wake(4'hf);
      cyc(3);
      chk("rwu_oe", remote_wake_oe, 1'h0);
      {power_good_in, wake_frame_mode_enable, wake_frame_match} = 3'h4;
      {link_change_mode_enable, link_change_seen} = 2'h3;
      cyc(6);
      chk("wake_mode", wake_mode_indicator, 1'h0);
      chk("rwu_out", remote_wake_out, 1'h1);
      {link_change_mode_enable, link_change_seen} = 2'h0;
      pci_rst_n = 1'h0;
      cyc(6);
      chk("xcvr_rst", transceiver_reset_out, 1'h1);
      chk("rwu_out", remote_wake_out, 1'h0);
      pci_rst_n = 1'h1;
      cyc(6);
      chk("xcvr_rst", transceiver_reset_out, 1'h0);
      load_wake(4'h1);
      cyc(2);
      chk("rwu_oe", remote_wake_oe, 1'h0);
      {link_change_mode_enable, link_change_seen} = 2'h3;
      cyc(3);
      chk("rwu_oe", remote_wake_oe, 1'h1);
      {link_change_mode_enable, link_change_seen} = 2'h0;
   endtask
   // external time base paces the transceiver reset
   task automatic t_tbase;
      {time_base_select, pci_rst_n} = 2'h2;
      cyc(6);
      chk("xcvr_rst", transceiver_reset_out, 1'h0);
      ext_time_base_clock = 1'h1;
      cyc(3);
      chk("tb_tick", time_base_tick, 1'h1);
      chk("xcvr_rst", transceiver_reset_out, 1'h1);
      cyc(1);
      chk("tb_tick", time_base_tick, 1'h0);
      {pci_rst_n, time_base_select, ext_time_base_clock} = 3'h4;
      cyc(6);
      chk("xcvr_rst", transceiver_reset_out, 1'h0);
   endtask
   task automatic wrap_up;
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // main sequence after the power-on reset
   initial begin
      repeat (8) @(posedge clk);
      cyc(1);
      rst_n = 1'h1;
      cyc(6);
      t_lamp();
      t_pme();
      t_strap();
      t_wake();
      t_tbase();
      wrap_up();
   end
endmodule
